// ---- pkg/tpm_pkg.sv ----
package tpm_pkg;
  // register indices of the two-port file
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ERR = 4'h1;
  localparam logic [3:0] REG_PARAM2 = 4'h2;
  localparam logic [3:0] REG_PARAM3 = 4'h3;
  localparam logic [3:0] REG_USER4 = 4'h4;
  localparam logic [3:0] REG_USER5 = 4'h5;
  localparam logic [3:0] REG_USER8 = 4'h8;
  localparam logic [3:0] REG_USER9 = 4'h9;
  localparam logic [3:0] REG_USER12 = 4'hc;
  localparam int USER_FIRST = 4;
  localparam int NUM_REGS = 16;
  // command register fields
  localparam int CMD_EXIT_BIT = 15;
  localparam int CMD_TEST_BIT = 15;
  localparam int CMD_HWRESET_BIT = 14;
  localparam int DBG_PROCEED_BIT = 4;
  localparam int DBG_GO_BIT = 3;
  localparam int DBG_DEPOSIT_BIT = 2;
  localparam int DBG_OPEN_REG_BIT = 1;
  localparam int DBG_OPEN_MEM_BIT = 0;
  // error and state register fields
  localparam int ERR_CMD_BIT = 15;
  localparam int ERR_DMA_BIT = 14;
  localparam int ERR_FATAL_BIT = 5;
  localparam int ERR_STACK_BIT = 3;
  localparam int STATE_MSB = 2;
  localparam logic [2:0] ST_UNAVAIL = 3'h0;
  localparam logic [2:0] ST_SELFTEST = 3'h1;
  localparam logic [2:0] ST_DEDTEST = 3'h2;
  localparam logic [2:0] ST_DEBUG = 3'h3;
  localparam logic [2:0] ST_WAITING = 3'h4;
  localparam logic [2:0] ST_TAPELOAD = 3'h5;
  localparam logic [2:0] ST_RESERVED = 3'h6;
  localparam logic [2:0] ST_USER = 3'h7;
  // reset values
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] ERR_RESET = 16'h0001;
  localparam logic [15:0] PARAM2_RESET = 16'h0000;
  localparam int BOOT_LSB = 4;
  // self-test result bit positions in the second parameter register
  localparam int RES_CSR_BIT = 0;
  localparam int RES_LCLK_BIT = 4;
  localparam int RES_CONSOLE_BIT = 5;
  localparam int RES_MPSERIAL_BIT = 6;
  localparam int RES_PARPORT_BIT = 7;
  localparam int RES_DMA_BIT = 8;
  // open-register codes: general registers 0..7, status word 8
  localparam logic [15:0] REGCODE_PSW = 16'h0008;
  localparam int MEM_HI_BITS = 6;
  // user interrupts: priority level and vectors
  localparam logic [2:0] USER_IRQ_LEVEL = 3'h5;
  localparam logic [8:0] VEC_USER4 = 9'h050;
  localparam logic [8:0] VEC_USER8 = 9'h054;
  localparam logic [8:0] VEC_USER12 = 9'h05c;

  typedef enum logic [2:0] {
    OP_PROCEED = 3'h0,
    OP_GO = 3'h1,
    OP_DEP_REG = 3'h2,
    OP_DEP_MEM = 3'h3,
    OP_OPEN_REG = 3'h4,
    OP_OPEN_MEM = 3'h5
  } tpm_op_e;

  typedef enum logic {
    FSM_IDLE = 1'b0,
    FSM_WAIT = 1'b1
  } tpm_fsm_e;

  function automatic logic tpm_reg_code_ok(input logic [15:0] code);
    tpm_reg_code_ok = (code <= REGCODE_PSW);
  endfunction : tpm_reg_code_ok

  function automatic logic tpm_is_user(input logic [3:0] addr);
    tpm_is_user = (addr >= 4'(USER_FIRST));
  endfunction : tpm_is_user
endpackage : tpm_pkg

// ---- logic/tpm_user_mem.sv ----
`timescale 1ns/1ns
module tpm_user_mem
  import tpm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_host_we,
  input wire logic [3:0] i_host_waddr,
  input wire logic [15:0] i_host_wdata,
  input wire logic i_loc_we,
  input wire logic [3:0] i_loc_waddr,
  input wire logic [15:0] i_loc_wdata,
  input wire logic [3:0] i_host_raddr,
  input wire logic [3:0] i_loc_raddr,
  output logic [15:0] o_host_rdata,
  output logic [15:0] o_loc_rdata
);
  logic [15:0] mem_reg [NUM_REGS];

  // words below the user range stay zero
  genvar g;
  for (g = 0; g < NUM_REGS; g++) begin : g_word
    always_ff @(posedge i_mclk) begin
      if (i_reset || g < USER_FIRST) begin
        mem_reg[g] <= 16'h0000;
      end else if (i_loc_we && i_loc_waddr == 4'(g)) begin
        mem_reg[g] <= i_loc_wdata;
      end else if (i_host_we && i_host_waddr == 4'(g)) begin
        mem_reg[g] <= i_host_wdata;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    o_host_rdata <= mem_reg[i_host_raddr];
    o_loc_rdata <= mem_reg[i_loc_raddr];
  end
endmodule : tpm_user_mem

// ---- logic/tpm_dbg_decode.sv ----
`timescale 1ns/1ns
module tpm_dbg_decode
  import tpm_pkg::*;
(
  input wire logic [15:0] i_cmd,
  output logic o_exit,
  output logic o_valid,
  output tpm_op_e o_op
);
  // highest set bit wins among the debug commands
  always_comb begin
    o_exit = i_cmd[CMD_EXIT_BIT];
    o_valid = 1'b1;
    o_op = OP_PROCEED;
    if (i_cmd[DBG_PROCEED_BIT]) begin
      o_op = OP_PROCEED;
    end else if (i_cmd[DBG_GO_BIT]) begin
      o_op = OP_GO;
    end else if (i_cmd[DBG_DEPOSIT_BIT]) begin
      o_op = OP_DEP_REG;
    end else if (i_cmd[DBG_OPEN_REG_BIT]) begin
      o_op = OP_OPEN_REG;
    end else if (i_cmd[DBG_OPEN_MEM_BIT]) begin
      o_op = OP_OPEN_MEM;
    end else begin
      o_valid = 1'b0;
    end
  end
endmodule : tpm_dbg_decode

// ---- logic/tpm_mailbox.sv ----
`timescale 1ns/1ns
module tpm_mailbox
  import tpm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [3:0] i_boot_switch,
  input wire logic i_user_enable,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [3:0] i_host_addr,
  input wire logic [15:0] i_host_wdata,
  output logic [15:0] o_host_rdata,
  output logic o_host_rvalid,
  input wire logic i_loc_wr,
  input wire logic i_loc_rd,
  input wire logic [3:0] i_loc_addr,
  input wire logic [15:0] i_loc_wdata,
  output logic [15:0] o_loc_rdata,
  output logic o_loc_rvalid,
  input wire logic i_test_fail,
  input wire logic [3:0] i_test_bit,
  input wire logic [3:0] i_test_code,
  input wire logic i_dma_abort,
  input wire logic i_stack_violation,
  input wire logic i_fatal_error,
  output logic o_cmd_strobe,
  output logic o_cmd_is_test,
  output logic o_ctx_req,
  output tpm_op_e o_ctx_op,
  output logic [21:0] o_ctx_addr,
  output logic [15:0] o_ctx_wdata,
  input wire logic i_ctx_ack,
  input wire logic [15:0] i_ctx_rdata,
  output logic o_hw_reset,
  output logic [2:0] o_user_irq,
  output logic [8:0] o_irq_vector,
  output logic [2:0] o_irq_level,
  output logic o_debug_mode
);
  logic [15:0] cmd_reg;
  logic [15:0] err_reg;
  logic [15:0] param2_reg;
  logic [15:0] param3_reg;
  tpm_fsm_e fsm_reg;
  logic open_valid_reg;
  logic open_mem_reg;
  logic [21:0] open_addr_reg;
  logic [15:0] host_spec_reg;
  logic [15:0] loc_spec_reg;
  logic host_rd_reg;
  logic loc_rd_reg;
  logic host_user_reg;
  logic host_hide_reg;
  logic loc_user_reg;
  logic [15:0] mem_host_rdata;
  logic [15:0] mem_loc_rdata;
  logic fatal;
  logic dbg_mode;
  logic host_cmd_wr;
  logic host_mem_we;
  logic dec_exit;
  logic dec_valid;
  tpm_op_e dec_op;
  tpm_op_e launch_op;
  logic launch;
  logic cmd_error;
  logic ack_open;

  assign fatal = err_reg[ERR_FATAL_BIT];
  assign dbg_mode = (err_reg[STATE_MSB:0] == ST_DEBUG);
  assign host_cmd_wr = i_host_wr && i_host_addr == REG_CMD && !fatal;
  assign host_mem_we = i_host_wr && tpm_is_user(i_host_addr) &&
    i_user_enable && i_host_addr != REG_USER5 &&
    i_host_addr != REG_USER9;

  tpm_dbg_decode u_decode (
    .i_cmd(i_host_wdata),
    .o_exit(dec_exit),
    .o_valid(dec_valid),
    .o_op(dec_op)
  );

  tpm_user_mem u_mem (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_host_we(host_mem_we),
    .i_host_waddr(i_host_addr),
    .i_host_wdata(i_host_wdata),
    .i_loc_we(i_loc_wr),
    .i_loc_waddr(i_loc_addr),
    .i_loc_wdata(i_loc_wdata),
    .i_host_raddr(i_host_addr),
    .i_loc_raddr(i_loc_addr),
    .o_host_rdata(mem_host_rdata),
    .o_loc_rdata(mem_loc_rdata)
  );

  // deposit goes to the open target
  assign launch_op = (dec_op == OP_DEP_REG && open_mem_reg) ?
    OP_DEP_MEM : dec_op;
  // debug layout only in debug state
  always_comb begin
    launch = 1'b0;
    cmd_error = 1'b0;
    if (host_cmd_wr && dbg_mode && !dec_exit && dec_valid) begin
      if (fsm_reg != FSM_IDLE) begin
        cmd_error = 1'b1;
      end else if (dec_op == OP_OPEN_REG && !tpm_reg_code_ok(param3_reg)) begin
        cmd_error = 1'b1;
      end else if (dec_op == OP_DEP_REG && !open_valid_reg) begin
        cmd_error = 1'b1;
      end else begin
        launch = 1'b1;
      end
    end
  end
  assign ack_open = fsm_reg == FSM_WAIT && i_ctx_ack &&
    (o_ctx_op == OP_OPEN_REG || o_ctx_op == OP_OPEN_MEM);

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmd_reg <= CMD_RESET;
    end else if (i_loc_wr && i_loc_addr == REG_CMD) begin
      cmd_reg <= i_loc_wdata;
    end else if (host_cmd_wr) begin
      cmd_reg <= i_host_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      err_reg <= ERR_RESET;
    end else begin
      if (i_loc_wr && i_loc_addr == REG_ERR) begin
        err_reg <= i_loc_wdata;
      end
      if (host_cmd_wr && dbg_mode && dec_exit) begin
        err_reg[STATE_MSB:0] <= ST_WAITING;
      end
      if (i_fatal_error) begin
        err_reg[ERR_FATAL_BIT] <= 1'b1;
        err_reg[STATE_MSB:0] <= ST_UNAVAIL;
      end
      if (cmd_error) begin
        err_reg[ERR_CMD_BIT] <= 1'b1;
      end
      if (i_dma_abort) begin
        err_reg[ERR_DMA_BIT] <= 1'b1;
      end
      if (i_stack_violation) begin
        err_reg[ERR_STACK_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      param2_reg <= PARAM2_RESET;
    end else begin
      if (i_host_wr && i_host_addr == REG_PARAM2) begin
        param2_reg <= i_host_wdata;
      end
      if (ack_open) begin
        param2_reg <= i_ctx_rdata;
      end
      if (i_loc_wr && i_loc_addr == REG_PARAM2) begin
        param2_reg <= i_loc_wdata;
      end
      if (i_test_fail) begin
        param2_reg[i_test_bit] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      param3_reg <= {8'h00, i_boot_switch, 4'h0};
    end else if (i_test_fail) begin
      param3_reg <= {12'h000, i_test_code};
    end else if (i_loc_wr && i_loc_addr == REG_PARAM3) begin
      param3_reg <= i_loc_wdata;
    end else if (i_host_wr && i_host_addr == REG_PARAM3) begin
      param3_reg <= i_host_wdata;
    end
  end

  // debug command handshake with the local processor
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      fsm_reg <= FSM_IDLE;
      o_ctx_req <= 1'b0;
      o_ctx_op <= OP_PROCEED;
      o_ctx_addr <= 22'h000000;
      o_ctx_wdata <= 16'h0000;
    end else begin
      unique case (fsm_reg)
        FSM_IDLE: begin
          if (launch) begin
            fsm_reg <= FSM_WAIT;
            o_ctx_req <= 1'b1;
            o_ctx_op <= launch_op;
            o_ctx_wdata <= param2_reg;
            if (launch_op == OP_OPEN_MEM) begin
              o_ctx_addr <= {param2_reg[MEM_HI_BITS-1:0], param3_reg};
            end else if (launch_op == OP_DEP_REG ||
                         launch_op == OP_DEP_MEM) begin
              o_ctx_addr <= open_addr_reg;
            end else begin
              o_ctx_addr <= {6'h00, param3_reg};
            end
          end
        end
        FSM_WAIT: begin
          if (i_ctx_ack) begin
            fsm_reg <= FSM_IDLE;
            o_ctx_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // proceed or go closes the open target
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      open_valid_reg <= 1'b0;
      open_mem_reg <= 1'b0;
      open_addr_reg <= 22'h000000;
    end else if (launch && (dec_op == OP_OPEN_REG ||
                            dec_op == OP_OPEN_MEM)) begin
      open_valid_reg <= 1'b1;
      open_mem_reg <= (dec_op == OP_OPEN_MEM);
      open_addr_reg <= (dec_op == OP_OPEN_MEM) ?
        {param2_reg[MEM_HI_BITS-1:0], param3_reg} : {6'h00, param3_reg};
    end else if (launch && (dec_op == OP_PROCEED || dec_op == OP_GO)) begin
      open_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_cmd_strobe <= 1'b0;
      o_cmd_is_test <= 1'b0;
      o_hw_reset <= 1'b0;
      o_debug_mode <= 1'b0;
    end else begin
      o_cmd_strobe <= host_cmd_wr && !dbg_mode;
      if (host_cmd_wr && !dbg_mode) begin
        o_cmd_is_test <= i_host_wdata[CMD_TEST_BIT];
      end
      // only the reset bit is heard
      o_hw_reset <= i_host_wr && i_host_addr == REG_CMD && fatal &&
        i_host_wdata[CMD_HWRESET_BIT];
      o_debug_mode <= dbg_mode;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_user_irq <= 3'h0;
      o_irq_vector <= 9'h000;
      o_irq_level <= 3'h0;
    end else begin
      o_user_irq <= {host_mem_we && i_host_addr == REG_USER12,
                     host_mem_we && i_host_addr == REG_USER8,
                     host_mem_we && i_host_addr == REG_USER4};
      o_irq_level <= USER_IRQ_LEVEL;
      if (host_mem_we && i_host_addr == REG_USER4) begin
        o_irq_vector <= VEC_USER4;
      end else if (host_mem_we && i_host_addr == REG_USER8) begin
        o_irq_vector <= VEC_USER8;
      end else if (host_mem_we && i_host_addr == REG_USER12) begin
        o_irq_vector <= VEC_USER12;
      end
    end
  end

  function automatic logic [15:0] spec_read(input logic [3:0] addr);
    unique case (addr)
      REG_CMD: spec_read = cmd_reg;
      REG_ERR: spec_read = err_reg;
      REG_PARAM2: spec_read = param2_reg;
      REG_PARAM3: spec_read = param3_reg;
      default: spec_read = 16'h0000;
    endcase
  endfunction : spec_read

  // two-cycle read path for both ports
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      host_rd_reg <= 1'b0;
      loc_rd_reg <= 1'b0;
      host_spec_reg <= 16'h0000;
      loc_spec_reg <= 16'h0000;
      host_user_reg <= 1'b0;
      host_hide_reg <= 1'b0;
      loc_user_reg <= 1'b0;
      o_host_rdata <= 16'h0000;
      o_loc_rdata <= 16'h0000;
      o_host_rvalid <= 1'b0;
      o_loc_rvalid <= 1'b0;
    end else begin
      host_rd_reg <= i_host_rd;
      loc_rd_reg <= i_loc_rd;
      host_spec_reg <= spec_read(i_host_addr);
      loc_spec_reg <= spec_read(i_loc_addr);
      host_user_reg <= tpm_is_user(i_host_addr);
      host_hide_reg <= !i_user_enable;
      loc_user_reg <= tpm_is_user(i_loc_addr);
      o_host_rvalid <= host_rd_reg;
      o_loc_rvalid <= loc_rd_reg;
      if (host_rd_reg) begin
        o_host_rdata <= !host_user_reg ? host_spec_reg :
          (host_hide_reg ? 16'h0000 : mem_host_rdata);
      end
      if (loc_rd_reg) begin
        o_loc_rdata <= loc_user_reg ? mem_loc_rdata : loc_spec_reg;
      end
    end
  end

  sequence s_dbg_write(int bitpos);
    host_cmd_wr && dbg_mode && i_host_wdata[bitpos];
  endsequence

  a_test_result: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_test_fail |=> param2_reg[$past(i_test_bit)] &&
      param3_reg == {12'h000, $past(i_test_code)})
    else $error("test failure not reported");
  a_exit_debug: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    s_dbg_write(CMD_EXIT_BIT) ##0 (!i_loc_wr && !i_fatal_error) |=>
      err_reg[STATE_MSB:0] == ST_WAITING)
    else $error("exit did not leave debug mode");
  a_open_mem_addr: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    launch && dec_op == OP_OPEN_MEM |=> o_ctx_req &&
      o_ctx_addr == {$past(param2_reg[5:0]), $past(param3_reg)})
    else $error("memory address formed wrongly");
  a_bad_reg_code: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    s_dbg_write(DBG_OPEN_REG_BIT) ##0 (!i_host_wdata[CMD_EXIT_BIT] &&
      !(|i_host_wdata[4:2]) && fsm_reg == FSM_IDLE &&
      param3_reg > REGCODE_PSW) |=>
      err_reg[ERR_CMD_BIT] && !o_ctx_req)
    else $error("bad register code not flagged");
  a_err_host_ro: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_host_wr && i_host_addr == REG_ERR && !i_loc_wr && !cmd_error &&
      !i_dma_abort && !i_stack_violation && !i_fatal_error |=>
      $stable(err_reg))
    else $error("host changed error register");
  a_fatal_reset: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    fatal && i_host_wr && i_host_addr == REG_CMD |=>
      o_hw_reset == $past(i_host_wdata[CMD_HWRESET_BIT]) && !o_cmd_strobe)
    else $error("fatal state did not gate commands");
  a_user_irq: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_host_wr && i_host_addr == REG_USER8 && i_user_enable |=>
      o_user_irq == 3'h2 && o_irq_vector == VEC_USER8)
    else $error("user interrupt missing");
  a_param3_reset: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    $past(i_reset) |-> param3_reg ==
      {8'h00, $past(i_boot_switch), 4'h0})
    else $error("third register reset value wrong");
  a_open_return: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    ack_open && !i_loc_wr && !i_test_fail |=>
      param2_reg == $past(i_ctx_rdata) && !o_ctx_req)
    else $error("opened value not returned");
  a_read_latency: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_host_rd && tpm_is_user(i_host_addr) && !i_user_enable |->
      ##2 o_host_rvalid && o_host_rdata == 16'h0000)
    else $error("disabled user register visible");
endmodule : tpm_mailbox

// ---- verification/tpm_local_model.sv ----
`timescale 1ns/1ns
module tpm_local_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ctx_req,
  input wire logic [3:0] i_delay,
  input wire logic [15:0] i_value,
  output logic o_ctx_ack,
  output logic [15:0] o_ctx_rdata
);
  logic [3:0] wait_reg;
  always_ff @(posedge i_mclk) begin
    if (i_reset || o_ctx_ack) begin
      o_ctx_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else if (i_ctx_req) begin
      if (wait_reg == i_delay)
        o_ctx_ack <= 1'b1;
      else
        wait_reg <= wait_reg + 4'h1;
    end
  end
  assign o_ctx_rdata = o_ctx_ack ? i_value : ~i_value;
endmodule : tpm_local_model

// ---- verification/test_two_port_command_mailbox.sv ----
`timescale 1ns/1ns
module test_two_port_command_mailbox;
  import tpm_pkg::*;
  logic mclk = 0, reset = 1, uen = 0, hw = 0, hr = 0, lw = 0, lr = 0;
  logic tf = 0, dab = 0, stk = 0, fat = 0, req, ack, hv, lv;
  logic [3:0] sw = 4'h9, ha = 0, la = 0, tb = 0, tc = 0, dly = 0;
  logic [15:0] hd = 0, ld = 0, val = 0, hq, lq, crd, wdo;
  logic [21:0] cad;
  logic cst, cit, hwrst, dbm;
  logic [2:0] uirq, lvl;
  logic [8:0] vec;
  tpm_op_e cop;
  int num_errors = 0, samples_checked = 0, cycles = 0;

  tpm_mailbox i_tpm_mailbox (.i_mclk(mclk), .i_reset(reset),
    .i_boot_switch(sw), .i_user_enable(uen), .i_host_wr(hw),
    .i_host_rd(hr), .i_host_addr(ha), .i_host_wdata(hd),
    .o_host_rdata(hq), .o_host_rvalid(hv), .i_loc_wr(lw), .i_loc_rd(lr),
    .i_loc_addr(la), .i_loc_wdata(ld), .o_loc_rdata(lq),
    .o_loc_rvalid(lv), .i_test_fail(tf), .i_test_bit(tb),
    .i_test_code(tc), .i_dma_abort(dab), .i_stack_violation(stk),
    .i_fatal_error(fat), .o_cmd_strobe(cst), .o_cmd_is_test(cit),
    .o_ctx_req(req), .o_ctx_op(cop), .o_ctx_addr(cad),
    .o_ctx_wdata(wdo), .i_ctx_ack(ack), .i_ctx_rdata(crd),
    .o_hw_reset(hwrst), .o_user_irq(uirq), .o_irq_vector(vec),
    .o_irq_level(lvl), .o_debug_mode(dbm));
  tpm_local_model i_tpm_local_model (.i_mclk(mclk), .i_reset(reset),
    .i_ctx_req(req), .i_delay(dly), .i_value(val), .o_ctx_ack(ack),
    .o_ctx_rdata(crd));

  always #50 mclk = ~mclk;

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      close_out;
    end
  end

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input bit loc, input logic [3:0] a, input logic [15:0] d);
    @(negedge mclk);
    if (loc) begin lw = 1; la = a; ld = d; end
    else begin hw = 1; ha = a; hd = d; end
    @(negedge mclk);
    lw = 0;
    hw = 0;
  endtask : wr

  task automatic rd(input bit loc, input logic [3:0] a, input logic [15:0] e);
    @(negedge mclk);
    if (loc) begin lr = 1; la = a; end
    else begin hr = 1; ha = a; end
    @(negedge mclk);
    lr = 0;
    hr = 0;
    @(posedge mclk);
    #1;
    if (loc) chk(lv === 1'b1 && lq === e, "local read");
    else chk(hv === 1'b1 && hq === e, "host read");
  endtask : rd

  task automatic nxt;
    @(posedge mclk);
    #1;
  endtask : nxt

  task automatic t_access;
    rd(0, 4'h0, 16'h0000);
    rd(0, 4'h1, 16'h0001);
    rd(0, 4'h3, {8'h00, sw, 4'h0});
    wr(0, 4'h1, 16'hffff);
    rd(0, 4'h1, 16'h0001);
    wr(1, 4'h2, 16'h5a5a);
    rd(0, 4'h2, 16'h5a5a);
    wr(0, 4'h2, 16'ha5a5);
    rd(1, 4'h2, 16'ha5a5);
    @(negedge mclk);
    hw = 1; ha = 4'h3; hd = 16'h1111; lw = 1; la = 4'h3; ld = 16'h2222;
    @(negedge mclk);
    hw = 0;
    lw = 0;
    rd(0, 4'h3, 16'h2222);
    wr(1, 4'h2, 16'h0000);
  endtask : t_access

  task automatic t_tests;
    logic [3:0] bits [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    logic [3:0] codes [6] = '{4'h7, 4'h3, 4'h6, 4'h5, 4'h7, 4'h5};
    logic [15:0] acc = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk);
      tf = 1; tb = bits[i]; tc = codes[i];
      @(negedge mclk);
      tf = 0;
      acc[bits[i]] = 1'b1;
      rd(0, 4'h2, acc);
      rd(0, 4'h3, {12'h000, codes[i]});
    end
    @(negedge mclk);
    dab = 1; stk = 1;
    @(negedge mclk);
    dab = 0;
    stk = 0;
    rd(0, 4'h1, 16'h4009);
  endtask : t_tests

  task automatic dbg(input logic [15:0] c, input tpm_op_e op,
                     input logic [21:0] a, input logic [15:0] wd,
                     input logic [3:0] d, input logic [15:0] v);
    int n = 0;
    dly = d;
    val = v;
    wr(0, 4'h0, c);
    while (req !== 1'b1 && n < 20) begin nxt; n++; end
    chk(cop === op, "debug op");
    if (op != OP_PROCEED) chk(cad === a, "debug address");
    if (op inside {OP_DEP_REG, OP_DEP_MEM}) chk(wdo === wd, "deposit data");
    while (req === 1'b1 && n < 40) begin nxt; n++; end
    chk(n < 40, "debug request stuck");
  endtask : dbg

  task automatic t_debug;
    wr(1, 4'h1, 16'h0003);
    wr(0, 4'h3, 16'h0003);
    chk(dbm === 1'b1, "debug mode flag");
    // host sends only debug commands in state 011
    dbg(16'h0002, OP_OPEN_REG, 22'h000003, 16'h0, 4'h0, 16'h1357);
    rd(0, 4'h2, 16'h1357);
    wr(0, 4'h2, 16'h2468);
    dbg(16'h0004, OP_DEP_REG, 22'h000003, 16'h2468, 4'h5, 16'h0);
    wr(0, 4'h2, 16'h002a);
    wr(0, 4'h3, 16'h1234);
    dbg(16'h0001, OP_OPEN_MEM, 22'h2a1234, 16'h0, 4'h2, 16'hbeef);
    rd(0, 4'h2, 16'hbeef);
    dbg(16'h0004, OP_DEP_MEM, 22'h2a1234, 16'hbeef, 4'h1, 16'h0);
    wr(0, 4'h3, 16'h0400);
    dbg(16'h0008, OP_GO, 22'h000400, 16'h0, 4'h3, 16'h0);
    dbg(16'h0010, OP_PROCEED, 22'h0, 16'h0, 4'h0, 16'h0);
    wr(0, 4'h3, 16'h0009);
    wr(0, 4'h0, 16'h0002);
    rd(0, 4'h1, 16'h8003);
    wr(0, 4'h0, 16'h8000);
    rd(0, 4'h1, 16'h8004);
    chk(dbm === 1'b0, "debug mode flag left");
  endtask : t_debug

  task automatic t_user;
    logic [3:0] ads [3] = '{4'h4, 4'h8, 4'hc};
    logic [8:0] vs [3] = '{9'h050, 9'h054, 9'h05c};
    wr(0, 4'h4, 16'h1111);
    rd(0, 4'h4, 16'h0000);
    uen = 1;
    for (int i = 0; i < 3; i++) begin
      wr(0, ads[i], 16'h1111);
      chk(uirq === 3'(1 << i) && vec === vs[i], "user irq");
      chk(lvl === 3'h5, "irq level");
    end
    wr(0, 4'h5, 16'hffff);
    rd(0, 4'h5, 16'h0000);
    wr(1, 4'h9, 16'h7777);
    rd(0, 4'h9, 16'h7777);
  endtask : t_user

  task automatic t_cmd_fatal;
    for (int t = 0; t < 2; t++) begin
      wr(0, 4'h0, {t[0], 15'h0001});
      chk(cst === 1'b1 && cit === t[0], "command strobe");
    end
    @(negedge mclk);
    fat = 1;
    @(negedge mclk);
    fat = 0;
    rd(0, 4'h1, 16'h8020);
    wr(0, 4'h0, 16'h0001);
    chk(cst === 1'b0, "command while fatal");
    wr(0, 4'h0, 16'h4000);
    chk(hwrst === 1'b1, "hardware reset");
  endtask : t_cmd_fatal

  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    reset = 0;
    t_access;
    t_tests;
    t_debug;
    t_user;
    t_cmd_fatal;
    close_out;
  end
endmodule : test_two_port_command_mailbox
